// ### logic/cmc_pkg.sv
// constants and types for the codec mode change and calibration control
package cmc_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_IFC  = 8'h08;
    localparam logic [7:0] A_FSPB = 8'h0c;
    localparam logic [7:0] A_CAP  = 8'h10;
    localparam logic [7:0] A_ALT  = 8'h14;
    // ==========================================================
    // field positions
    localparam int CTRL_MCE  = 0;
    localparam int STAT_CIP  = 0;
    localparam int STAT_BUSY = 1;
    localparam int IFC_PEN   = 0;
    localparam int IFC_CEN   = 1;
    localparam int IFC_CAL   = 2;
    localparam int FS_SRC    = 0;
    localparam int FS_DIV    = 1;
    localparam int ALT_XTAL  = 0;
    localparam int ALT_SPE   = 1;
    localparam int ALT_SF    = 2;
    localparam int ALT_PUN   = 4;
    localparam int ALT_CUN   = 5;
    localparam int ALT_M2    = 6;
    // ==========================================================
    // reset values and masks
    localparam logic [7:0] RST_IFC  = 8'h0c;
    localparam logic [7:0] RST_FSPB = 8'h00;
    localparam logic [7:0] RST_CAP  = 8'h00;
    localparam logic [7:0] RST_ALT  = 8'h00;
    localparam logic [7:0] BUSY_VAL = 8'h80;
    localparam logic [7:0] M_EN     = 8'h03;
    localparam logic [7:0] M_LO     = 8'h0f;
    localparam logic [7:0] M_HI     = 8'hf0;
    localparam logic [7:0] M_ALT_G  = 8'h0e;
    // ==========================================================
    // durations in sample periods
    localparam logic [7:0] CAL_SW_SMP   = 8'd40;
    localparam logic [7:0] CAL_CONV_SMP = 8'd136;
    localparam logic [7:0] CAL_DAC_SMP  = 8'd40;
    localparam logic [7:0] CAL_FULL_SMP = 8'd168;
    localparam logic [7:0] RESYNC_SMP   = 8'd2;
    localparam logic [7:0] OSC_SMP      = 8'd4;
    // ==========================================================
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_PDOWN, ST_INIT, ST_IDLE, ST_RESYNC, ST_OSCW, ST_CAL
    } cmc_state_t;
endpackage : cmc_pkg

// ### logic/cmc_ctrl.sv
// codec power-down, init, gated configuration, calibration and clock switching
// Summary of operation
// - power down: reads 0x80, mute, reference off
// - power-down release starts initialization with calibration
// - initializing: reads 0x80, writes dropped
// - registers hold reset values after initialization
// - reset runs same initialization at power-up
// - buffer enable and direction, both idle high
// - config, rate, serial bits need gate set
// - format nibble needs gate or unlock bit
// - enables ungated, applied when DMA idle
// - gate falling edge runs selected calibration
// - in-progress bit high during calibration; host polls
// - select 00: no mute, 40 once
// - select 01: mute DACs, 136 samples
// - select 10: mute DACs, 40 samples
// - select 11 or init: mute all, 168
// - clock change resynchronizes, reads 0x80
// - keep oscillators: no 0x80; else wait oscillator
// - mode one: format only via gate
// - playback unlock flushes FIFO, no calibration
// - capture unlock flushes FIFO, no calibration
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cmc_ctrl #(
    parameter int SAMPLE_BASE_CYC = 1024
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    input  wire logic       power_down_n,
    input  wire logic       pb_dma_busy,
    input  wire logic       cap_dma_busy,
    output logic            buffer_enable_out,
    output logic            buffer_direction_out,
    output logic            dac_mute_out,
    output logic            mixer_mute_out,
    output logic            vref_on_out,
    output logic            osc1_run_out,
    output logic            osc2_run_out,
    output logic            playback_enable_out,
    output logic            capture_enable_out,
    output logic            pb_fifo_flush,
    output logic            cap_fifo_flush
);
    // ==========================================================
    // state
    typedef struct packed {
        cmc_pkg::cmc_state_t st;
        logic [7:0]  cnt;
        logic [17:0] div;
        logic        mode_change_gate;
        logic [7:0]  ifc;
        logic [7:0]  fs;
        logic [7:0]  cap;
        logic [7:0]  alt;
        logic [1:0]  cur_sel;
        logic [1:0]  last_sel;
        logic        osc_pend;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [7:0]  wdata;
        logic        wen;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        logic        buf_en;
        logic        buf_dir;
        logic        dac_mute;
        logic        mix_mute;
        logic        vref_on;
        logic        osc1;
        logic        osc2;
        logic        pb_en;
        logic        cap_en;
        logic        pb_flush;
        logic        cap_flush;
    } cmc_st_t;

    localparam cmc_st_t ST_RST = '{
        st: cmc_pkg::ST_INIT, cnt: cmc_pkg::CAL_FULL_SMP,
        ifc: cmc_pkg::RST_IFC, fs: cmc_pkg::RST_FSPB,
        cap: cmc_pkg::RST_CAP, alt: cmc_pkg::RST_ALT,
        cur_sel: 2'h3, last_sel: 2'h3, buf_en: 1'b1, buf_dir: 1'b1,
        dac_mute: 1'b1, mix_mute: 1'b1, default: '0};

    cmc_st_t s_ff;
    cmc_st_t nxt_s;

    function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] d,
                                         input logic [7:0] m);
        merge = (o & ~m) | (d & m);
    endfunction : merge

    // zero length means go straight back to idle
    function automatic logic [7:0] cal_len(input logic [1:0] sel, input logic [1:0] last);
        case (sel)
            2'h0:    cal_len = (last != 2'h0) ? cmc_pkg::CAL_SW_SMP : 8'h00;
            2'h1:    cal_len = cmc_pkg::CAL_CONV_SMP;
            2'h2:    cal_len = cmc_pkg::CAL_DAC_SMP;
            default: cal_len = cmc_pkg::CAL_FULL_SMP;
        endcase
    endfunction : cal_len

    function automatic logic mapped(input logic [7:0] a);
        if (a == cmc_pkg::A_CTRL) mapped = 1'b1;
        else if (a == cmc_pkg::A_STAT) mapped = 1'b1;
        else if (a == cmc_pkg::A_IFC) mapped = 1'b1;
        else if (a == cmc_pkg::A_FSPB) mapped = 1'b1;
        else if (a == cmc_pkg::A_CAP) mapped = 1'b1;
        else if (a == cmc_pkg::A_ALT) mapped = 1'b1;
        else mapped = 1'b0;
    endfunction : mapped

    logic       busy;
    logic       tick;
    logic       do_wr;
    logic       mce_exit;
    logic       fmt_pb_ok;
    logic       fmt_cap_ok;
    logic [7:0] ln;
    logic [7:0] rd;

    // reads answer 0x80 and writes are dropped in these states
    assign busy = (s_ff.st == cmc_pkg::ST_PDOWN) || (s_ff.st == cmc_pkg::ST_INIT)
               || (s_ff.st == cmc_pkg::ST_RESYNC) || (s_ff.st == cmc_pkg::ST_OSCW);
    assign tick = (s_ff.div == 18'h0);
    assign do_wr = s_ff.aw_have && s_ff.w_have && !s_ff.bvalid;
    assign fmt_pb_ok = s_ff.mode_change_gate || (s_ff.alt[cmc_pkg::ALT_M2] && s_ff.alt[cmc_pkg::ALT_PUN]);
    assign fmt_cap_ok = s_ff.mode_change_gate || (s_ff.alt[cmc_pkg::ALT_M2] && s_ff.alt[cmc_pkg::ALT_CUN]);
    assign mce_exit = do_wr && !busy && s_ff.wen && (s_ff.awaddr == cmc_pkg::A_CTRL)
                   && s_ff.mode_change_gate && !s_ff.wdata[cmc_pkg::CTRL_MCE];
    assign ln = cal_len(s_ff.ifc[cmc_pkg::IFC_CAL +: 2], s_ff.last_sel);

    // ==========================================================
    // next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.pb_flush = 1'b0;
        nxt_s.cap_flush = 1'b0;
        // sample period divider; rate follows source and divide fields
        if (tick) begin
            nxt_s.div = 18'(({17'h0, s_ff.fs[cmc_pkg::FS_SRC]} + 18'(SAMPLE_BASE_CYC))
                        << s_ff.fs[cmc_pkg::FS_DIV +: 3]) - 18'h1;
        end else begin
            nxt_s.div = s_ff.div - 18'h1;
        end

        // bus slave: address and data taken in either order
        if (s_axi_awvalid && s_ff.awready) begin
            nxt_s.aw_have = 1'b1;
            nxt_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_ff.wready) begin
            nxt_s.w_have = 1'b1;
            nxt_s.wdata = s_axi_wdata[7:0];
            nxt_s.wen = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (do_wr) begin
            nxt_s.aw_have = 1'b0;
            nxt_s.w_have = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = mapped(s_ff.awaddr) ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
        end
        if (do_wr && !busy && s_ff.wen) begin
            if (s_ff.awaddr == cmc_pkg::A_CTRL) begin
                nxt_s.mode_change_gate = s_ff.wdata[cmc_pkg::CTRL_MCE];
            end else if (s_ff.awaddr == cmc_pkg::A_IFC) begin
                nxt_s.ifc = merge(s_ff.ifc, s_ff.wdata, s_ff.mode_change_gate ? 8'hff : cmc_pkg::M_EN);
            end else if (s_ff.awaddr == cmc_pkg::A_FSPB) begin
                if (s_ff.mode_change_gate) begin
                    nxt_s.fs = merge(nxt_s.fs, s_ff.wdata, cmc_pkg::M_LO);
                end
                if (fmt_pb_ok) begin
                    nxt_s.fs = merge(nxt_s.fs, s_ff.wdata, cmc_pkg::M_HI);
                end
                // clock source or divide changed in one write
                if (s_ff.mode_change_gate && (s_ff.wdata[3:0] != s_ff.fs[3:0])) begin
                    if (s_ff.wdata[cmc_pkg::FS_SRC] != s_ff.fs[cmc_pkg::FS_SRC]
                        && !s_ff.alt[cmc_pkg::ALT_XTAL]) begin
                        nxt_s.osc_pend = 1'b1;
                    end
                    if (!s_ff.alt[cmc_pkg::ALT_XTAL]) begin
                        nxt_s.st = cmc_pkg::ST_RESYNC;
                        nxt_s.cnt = cmc_pkg::RESYNC_SMP;
                    end
                end
            end else if (s_ff.awaddr == cmc_pkg::A_CAP) begin
                if (fmt_cap_ok) begin
                    nxt_s.cap = merge(s_ff.cap, s_ff.wdata, cmc_pkg::M_HI);
                end
            end else if (s_ff.awaddr == cmc_pkg::A_ALT) begin
                nxt_s.alt = merge(s_ff.alt, s_ff.wdata,
                                  s_ff.mode_change_gate ? 8'h7f : ~cmc_pkg::M_ALT_G & 8'h7f);
                // unlock rising in second mode flushes, never calibrates
                nxt_s.pb_flush = s_ff.wdata[cmc_pkg::ALT_M2] && s_ff.wdata[cmc_pkg::ALT_PUN]
                              && !s_ff.alt[cmc_pkg::ALT_PUN];
                nxt_s.cap_flush = s_ff.wdata[cmc_pkg::ALT_M2] && s_ff.wdata[cmc_pkg::ALT_CUN]
                               && !s_ff.alt[cmc_pkg::ALT_CUN];
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_ff.arready) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = mapped(s_axi_araddr) ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
            nxt_s.rdata = rd;
        end

        // sequencer
        case (s_ff.st)
            cmc_pkg::ST_PDOWN: begin
                // registers restart; a bus cycle in flight keeps its answer
                if (power_down_n) begin
                    nxt_s.st = cmc_pkg::ST_INIT;
                    nxt_s.cnt = ST_RST.cnt;
                    nxt_s.mode_change_gate = ST_RST.mode_change_gate;
                    nxt_s.ifc = ST_RST.ifc;
                    nxt_s.fs = ST_RST.fs;
                    nxt_s.cap = ST_RST.cap;
                    nxt_s.alt = ST_RST.alt;
                    nxt_s.cur_sel = ST_RST.cur_sel;
                    nxt_s.last_sel = ST_RST.last_sel;
                    nxt_s.osc_pend = ST_RST.osc_pend;
                end
            end
            cmc_pkg::ST_INIT, cmc_pkg::ST_RESYNC, cmc_pkg::ST_CAL: begin
                if (tick && s_ff.cnt <= 8'h1) begin
                    nxt_s.st = cmc_pkg::ST_IDLE;
                end else if (tick) begin
                    nxt_s.cnt = s_ff.cnt - 8'h1;
                end
            end
            cmc_pkg::ST_OSCW: begin
                if (tick && s_ff.cnt <= 8'h1) begin
                    nxt_s.osc_pend = 1'b0;
                    nxt_s.last_sel = s_ff.ifc[cmc_pkg::IFC_CAL +: 2];
                    nxt_s.cur_sel = s_ff.ifc[cmc_pkg::IFC_CAL +: 2];
                    nxt_s.cnt = ln;
                    nxt_s.st = (ln == 8'h0) ? cmc_pkg::ST_IDLE : cmc_pkg::ST_CAL;
                end else if (tick) begin
                    nxt_s.cnt = s_ff.cnt - 8'h1;
                end
            end
            default: begin
                if (mce_exit && s_ff.osc_pend) begin
                    nxt_s.st = cmc_pkg::ST_OSCW;
                    nxt_s.cnt = cmc_pkg::OSC_SMP;
                end else if (mce_exit) begin
                    nxt_s.last_sel = s_ff.ifc[cmc_pkg::IFC_CAL +: 2];
                    nxt_s.cur_sel = s_ff.ifc[cmc_pkg::IFC_CAL +: 2];
                    nxt_s.cnt = ln;
                    nxt_s.st = (ln == 8'h0) ? cmc_pkg::ST_IDLE : cmc_pkg::ST_CAL;
                end
            end
        endcase
        if (!power_down_n) begin
            nxt_s.st = cmc_pkg::ST_PDOWN;
        end

        // new enables wait for the current DMA sample to finish
        if (!pb_dma_busy) begin
            nxt_s.pb_en = s_ff.ifc[cmc_pkg::IFC_PEN];
        end
        if (!cap_dma_busy) begin
            nxt_s.cap_en = s_ff.ifc[cmc_pkg::IFC_CEN];
        end
        if (nxt_s.st == cmc_pkg::ST_PDOWN || nxt_s.st == cmc_pkg::ST_INIT) begin
            nxt_s.pb_en = 1'b0;
            nxt_s.cap_en = 1'b0;
        end

        nxt_s.awready = !nxt_s.aw_have;
        nxt_s.wready = !nxt_s.w_have;
        nxt_s.arready = !nxt_s.rvalid;
        // transceiver turns toward the bus only while read data is out
        nxt_s.buf_en = !(nxt_s.rvalid || do_wr);
        nxt_s.buf_dir = !nxt_s.rvalid;
        nxt_s.vref_on = (nxt_s.st != cmc_pkg::ST_PDOWN);
        nxt_s.dac_mute = (nxt_s.st == cmc_pkg::ST_PDOWN) || (nxt_s.st == cmc_pkg::ST_INIT)
                      || (nxt_s.st == cmc_pkg::ST_CAL && nxt_s.cur_sel != 2'h0);
        nxt_s.mix_mute = (nxt_s.st == cmc_pkg::ST_PDOWN) || (nxt_s.st == cmc_pkg::ST_INIT)
                      || (nxt_s.st == cmc_pkg::ST_CAL && nxt_s.cur_sel == 2'h3);
        // the unused oscillator stops unless both are kept
        nxt_s.osc1 = nxt_s.vref_on && (nxt_s.alt[cmc_pkg::ALT_XTAL]
                  || !nxt_s.fs[cmc_pkg::FS_SRC]);
        nxt_s.osc2 = nxt_s.vref_on && (nxt_s.alt[cmc_pkg::ALT_XTAL]
                  || nxt_s.fs[cmc_pkg::FS_SRC]);
    end

    // ==========================================================
    // read mux
    always_comb begin
        rd = 8'h00;
        if (busy && mapped(s_axi_araddr)) begin
            rd = cmc_pkg::BUSY_VAL;
        end else if (s_axi_araddr == cmc_pkg::A_CTRL) begin
            rd = {7'h0, s_ff.mode_change_gate};
        end else if (s_axi_araddr == cmc_pkg::A_STAT) begin
            rd = {6'h0, busy, s_ff.st == cmc_pkg::ST_CAL};
        end else if (s_axi_araddr == cmc_pkg::A_IFC) begin
            rd = s_ff.ifc;
        end else if (s_axi_araddr == cmc_pkg::A_FSPB) begin
            rd = s_ff.fs;
        end else if (s_axi_araddr == cmc_pkg::A_CAP) begin
            rd = s_ff.cap;
        end else if (s_axi_araddr == cmc_pkg::A_ALT) begin
            rd = s_ff.alt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= ST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready = s_ff.awready;
    assign s_axi_wready = s_ff.wready;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = s_ff.arready;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rresp = s_ff.rresp;
    assign s_axi_rdata = {24'h0, s_ff.rdata};
    assign buffer_enable_out = s_ff.buf_en;
    assign buffer_direction_out = s_ff.buf_dir;
    assign dac_mute_out = s_ff.dac_mute;
    assign mixer_mute_out = s_ff.mix_mute;
    assign vref_on_out = s_ff.vref_on;
    assign osc1_run_out = s_ff.osc1;
    assign osc2_run_out = s_ff.osc2;
    assign playback_enable_out = s_ff.pb_en;
    assign capture_enable_out = s_ff.cap_en;
    assign pb_fifo_flush = s_ff.pb_flush;
    assign cap_fifo_flush = s_ff.cap_flush;

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_busy_read_80: assert property (s_axi_arvalid && s_ff.arready && busy
        && mapped(s_axi_araddr) |=> s_axi_rdata == 32'h80)
        else $error("busy read not 0x80");
    a_pdown_mute: assert property (!power_down_n |=>
        (dac_mute_out && mixer_mute_out && !vref_on_out))
        else $error("power down did not mute");
    a_pdn_rise: assert property (s_ff.st == cmc_pkg::ST_PDOWN && power_down_n
        |=> s_ff.st == cmc_pkg::ST_INIT && s_ff.cnt == 8'd168)
        else $error("no init after power down");
    a_wr_drop: assert property (do_wr && busy
        && !(s_ff.st == cmc_pkg::ST_PDOWN && power_down_n)
        |=> $stable(s_ff.ifc) && $stable(s_ff.fs)
        && $stable(s_ff.alt) && $stable(s_ff.mode_change_gate))
        else $error("write taken while busy");
    a_init_regs: assert property ($past(s_ff.st) == cmc_pkg::ST_INIT
        && s_ff.st == cmc_pkg::ST_IDLE |-> s_ff.ifc == cmc_pkg::RST_IFC
        && s_ff.alt == cmc_pkg::RST_ALT)
        else $error("registers not at reset value");
    a_buf_read: assert property (s_axi_rvalid |-> !buffer_enable_out
        && !buffer_direction_out)
        else $error("buffer not turned for read");
    a_ifc_gate: assert property (do_wr && !busy && s_ff.awaddr == cmc_pkg::A_IFC
        && !s_ff.mode_change_gate |=> s_ff.ifc[7:2] == $past(s_ff.ifc[7:2]))
        else $error("gated config changed");
    a_cal_conv: assert property (mce_exit && !s_ff.osc_pend && s_ff.ifc[3:2] == 2'h1
        |=> s_ff.st == cmc_pkg::ST_CAL && s_ff.cnt == 8'd136 ##1 dac_mute_out)
        else $error("converter calibration wrong");
    a_cal_full: assert property (mce_exit && !s_ff.osc_pend && s_ff.ifc[3:2] == 2'h3
        |=> s_ff.cnt == 8'd168 ##1 mixer_mute_out)
        else $error("full calibration wrong");
    a_nocal_mute: assert property (s_ff.st == cmc_pkg::ST_CAL && s_ff.cur_sel == 2'h0
        && power_down_n |=> !dac_mute_out)
        else $error("no-cal mode muted");
    a_en_hold: assert property (pb_dma_busy && s_ff.st == cmc_pkg::ST_IDLE
        && power_down_n |=> playback_enable_out == $past(playback_enable_out))
        else $error("enable applied mid transfer");
    a_flush_nocal: assert property (pb_fifo_flush |-> s_ff.st != cmc_pkg::ST_CAL
        || $past(s_ff.st) == cmc_pkg::ST_CAL)
        else $error("flush started calibration");

    c_cal_done: cover property (s_ff.st == cmc_pkg::ST_CAL ##1 s_ff.st == cmc_pkg::ST_IDLE);
    c_resync: cover property (s_ff.st == cmc_pkg::ST_RESYNC);
    c_pdown: cover property (s_ff.st == cmc_pkg::ST_PDOWN ##1 s_ff.st == cmc_pkg::ST_INIT);
endmodule : cmc_ctrl

// ### verification/cmc_host_model.sv
// host side bus master model driving the control block registers
`timescale 1ns/100ps
module cmc_host_model (
    input  wire logic        aclk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // ==========================================================
    // bus cycles: each channel held until its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, d};
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d  = rdata[7:0];
        rs = rresp;
    endtask : rd
endmodule : cmc_host_model

// ### verification/test_codec_mode_change_calibration_control.sv
// self-checking bench for the mode change and calibration control
`timescale 1ns/100ps
module test_codec_mode_change_calibration_control;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        pwr_n = 1'b1;
    logic        pbb = 1'b0;
    logic        cpb = 1'b0;
    logic [7:0]  awaddr, araddr, v;
    logic [31:0] wdata, rdata;
    logic [1:0]  rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ben, bdir, dmute, mmute, vref, pen_o;
    logic        pfl, cfl, o1, o2;
    int          bad_count = 0;
    int          compares = 0;
    int          nfl = 0;
    int          t0;
    logic [1:0]  sel [5] = '{2'd1, 2'd2, 2'd3, 2'd0, 2'd0};
    int          len [5] = '{136, 40, 168, 40, 0};
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (aresetn) nfl <= nfl + pfl + cfl;
    cmc_ctrl #(.SAMPLE_BASE_CYC(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_down_n(pwr_n), .pb_dma_busy(pbb), .cap_dma_busy(cpb),
        .buffer_enable_out(ben), .buffer_direction_out(bdir), .dac_mute_out(dmute),
        .mixer_mute_out(mmute), .vref_on_out(vref), .osc1_run_out(o1), .osc2_run_out(o2),
        .playback_enable_out(pen_o), .capture_enable_out(), .pb_fifo_flush(pfl),
        .cap_fifo_flush(cfl));
    cmc_host_model host_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle();
        int n;
        n = 0;
        do begin
            host_u.rd(cmc_pkg::A_STAT, v, r);
            n++;
        end while ((v === 8'h80 || v[0] !== 1'b0) && n < 400);
        check(n < 400, 1'b1);
    endtask : settle
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // ==========================================================
    // tests
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        host_u.rd(cmc_pkg::A_IFC, v, r);
        check(v, 8'h80);
        host_u.wr(cmc_pkg::A_IFC, 8'h00);
        settle();
        host_u.rd(cmc_pkg::A_IFC, v, r);
        check(v, cmc_pkg::RST_IFC);
        @(posedge aclk);
        check({ben, bdir}, 2'b11);
        $display("test init done");
        host_u.wr(cmc_pkg::A_IFC, 8'h03);
        host_u.rd(cmc_pkg::A_IFC, v, r);
        check(v, 8'h0f);
        check(pen_o, 1'b1);
        pbb <= 1'b1;
        host_u.wr(cmc_pkg::A_IFC, 8'h02);
        check(pen_o, 1'b1);
        pbb <= 1'b0;
        repeat (3) @(posedge aclk);
        check(pen_o, 1'b0);
        $display("test gating done");
        for (int i = 0; i < 5; i++) begin
            host_u.wr(cmc_pkg::A_CTRL, 8'h01);
            host_u.wr(cmc_pkg::A_IFC, {4'h0, sel[i], 2'b10});
            host_u.wr(cmc_pkg::A_CTRL, 8'h00);
            t0 = $time / 20;
            repeat (2) @(posedge aclk);
            if (len[i] > 0) check(dmute, sel[i] != 2'd0);
            settle();
            t0 = $time / 20 - t0;
            check(t0 >= len[i] * 4 - 4 && t0 <= len[i] * 4 + 24, 1'b1);
        end
        $display("test calibration done");
        host_u.wr(cmc_pkg::A_CTRL, 8'h01);
        host_u.wr(cmc_pkg::A_FSPB, 8'h02);
        host_u.rd(cmc_pkg::A_CTRL, v, r);
        check(v, 8'h80);
        settle();
        host_u.rd(cmc_pkg::A_FSPB, v, r);
        check(v, 8'h02);
        host_u.wr(cmc_pkg::A_CTRL, 8'h00);
        settle();
        host_u.rd(8'h1c, v, r);
        check({r, v}, {cmc_pkg::RESP_SLVERR, 8'h00});
        host_u.wr(cmc_pkg::A_ALT, 8'h70);
        host_u.wr(cmc_pkg::A_FSPB, 8'ha3);
        host_u.wr(cmc_pkg::A_CAP, 8'hb0);
        host_u.rd(cmc_pkg::A_FSPB, v, r);
        check(v, 8'ha2);
        host_u.rd(cmc_pkg::A_CAP, v, r);
        check(v, 8'hb0);
        host_u.rd(cmc_pkg::A_STAT, v, r);
        check(v, 8'h00);
        check(nfl, 2);
        host_u.wr(cmc_pkg::A_CTRL, 8'h01);
        host_u.wr(cmc_pkg::A_FSPB, 8'ha3);
        settle();
        host_u.wr(cmc_pkg::A_CTRL, 8'h00);
        host_u.rd(cmc_pkg::A_CTRL, v, r);
        check(v, 8'h80);
        settle();
        check({o1, o2}, 2'b01);
        host_u.wr(cmc_pkg::A_ALT, 8'h71);
        host_u.wr(cmc_pkg::A_CTRL, 8'h01);
        host_u.wr(cmc_pkg::A_FSPB, 8'ha2);
        host_u.rd(cmc_pkg::A_CTRL, v, r);
        check(v, 8'h01);
        check({o1, o2}, 2'b11);
        host_u.wr(cmc_pkg::A_CTRL, 8'h00);
        $display("test clock change done");
        pwr_n <= 1'b0;
        repeat (2) @(posedge aclk);
        host_u.wr(cmc_pkg::A_IFC, 8'h00);
        host_u.rd(cmc_pkg::A_IFC, v, r);
        check(v, 8'h80);
        check({vref, dmute, mmute}, 3'b011);
        pwr_n <= 1'b1;
        repeat (2) @(posedge aclk);
        host_u.rd(cmc_pkg::A_STAT, v, r);
        check(v, 8'h80);
        settle();
        host_u.rd(cmc_pkg::A_IFC, v, r);
        check(v, cmc_pkg::RST_IFC);
        host_u.rd(cmc_pkg::A_FSPB, v, r);
        check(v, cmc_pkg::RST_FSPB);
        $display("test power down done");
        complete_run();
    end
    // long enough for two initializations and all calibrations with margin
    initial begin
        repeat (50000) @(posedge aclk);
        bad_count++;
        complete_run();
    end
endmodule : test_codec_mode_change_calibration_control
